// [smc_cfg.svh]
// constants of the sleep mode controller
// What this block does
// - idle halts cpu, peripherals run, pin/ccl/other irqs wake
// - standby stops fast clocks lacking run-in-standby
// - power-down stops every fast clock unconditionally
// - low-leakage bit cuts leakage in power-down with auto regulator mode
// - rtc wdt bod events always on; dac standby-gated
// - standby rtc counter gated; power-down pit only
// - main/ccl clocks standby-gated; tcd clock idle only
// - vlm, multi_voltage_io wake always; pin needs async in power-down; rtc not idle
// - ccl wake; power-down needs async path, no leakage
// - six cycles plus osc and regulator start-up
// - idle keeps main clock; power-down 32k on demand
// - wait for brown-out ready when fuse selects
// - debug break wakes to active without irq
// - key then protected write within four instructions
// - unkeyed regulator write ignored, value kept
// - mode codes idle 0, standby 1, power-down 2
// - sleep only if enable bit set at sleep instruction
// - irq wake resumes; reset ends sleep
// - power mode 0 auto, 1 full drive
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_MODE_IDLE       3'h0
`define SMC_MODE_STANDBY    3'h1
`define SMC_MODE_PDOWN      3'h2
`define SMC_REGULATOR_POWER_MODE_AUTO      3'h0
`define SMC_REGULATOR_POWER_MODE_FULL      3'h1
`define SMC_REG_RESET       8'h00
`define SMC_REG_MASK        8'h17
`define SMC_HTLL_BIT        4
`define SMC_REGULATOR_POWER_MODE_MSB       2
`define SMC_WAKE_CYCLES     3'h6
`define SMC_KEY_WINDOW      3'h4
`define SMC_BOD_WAIT_CODE   2'h3
`define SMC_IO_KEY_DEFAULT  8'h5A

`endif

// [smc_pkg.sv]
// types shared by the sleep mode controller
package smc_pkg;
`include "smc_cfg.svh"

    // selectable sleep modes
    typedef enum logic [2:0]
    {
        SMC_IDLE    = `SMC_MODE_IDLE,
        SMC_STANDBY = `SMC_MODE_STANDBY,
        SMC_PDOWN   = `SMC_MODE_PDOWN
    } smc_mode_type;

    // controller states, one-hot
    typedef enum logic [3:0]
    {
        SMC_ACTIVE = 4'b0001,
        SMC_SLEEP  = 4'b0010,
        SMC_START  = 4'b0100,
        SMC_COUNT  = 4'b1000
    } smc_state_type;
endpackage

// [smc_reg_if.sv]
// carrier between the controller and its protected register
`timescale 1ns/1ps
interface smc_reg_if;
    logic       key_wr;        // key write strobe
    logic [7:0] key_data;      // value written to protection register
    logic       instr_retired; // one cpu instruction finished
    logic       reg_wr;        // regulator register write strobe
    logic [7:0] reg_wdata;     // regulator register write data
    logic [7:0] reg_value;     // stored regulator register
    logic       window_open;   // protected write allowed now

    modport ctrl
    (
        input  key_wr, key_data, instr_retired, reg_wr, reg_wdata,
        output reg_value, window_open
    );
    modport user
    (
        output key_wr, key_data, instr_retired, reg_wr, reg_wdata,
        input  reg_value, window_open
    );
endinterface

// [smc_protect.sv]
// key-protected regulator control register
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_protect
#(
    parameter logic [7:0] IO_KEY = `SMC_IO_KEY_DEFAULT // arbitrary value
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // register traffic
    smc_reg_if.ctrl   bus
);
    import smc_pkg::*;

    logic [2:0] left;      // instructions left in the window
    logic [2:0] next_left; // next window count
    logic [7:0] next_reg;  // next register value
    wire        key_ok = bus.key_wr && (bus.key_data == IO_KEY);
    wire        open   = (left != 3'h0);
    // a key write with the matching key in the same cycle wins and the data write is refused
    wire        take   = bus.reg_wr && open && !key_ok;

    // key opens a window of four instructions; write closes it
    assign next_left = key_ok ? `SMC_KEY_WINDOW :
                       take   ? 3'h0 :
                       (open && bus.instr_retired) ? left - 3'h1 :
                       left;
    // unkeyed writes leave the register alone; reserved bits stay 0
    assign next_reg  = take ? (bus.reg_wdata & `SMC_REG_MASK)
                            : bus.reg_value;

    // window counter and register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            left          <= 3'h0;
            bus.reg_value <= `SMC_REG_RESET;
            bus.window_open <= 1'b0;
        end
        else
        begin
            left          <= next_left;
            bus.reg_value <= next_reg;
            bus.window_open <= (next_left != 3'h0);
        end
    end
endmodule

// [smc_top.sv]
// sleep mode controller: mode entry, clock gating, wake sequencing
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_top
(
    // clock and reset
    input  wire logic           SYS_CLK,
    input  wire logic           SYS_RST,
    // sleep control from the cpu
    input  wire logic [2:0]     SLEEP_MODE_SELECT,
    input  wire logic           SLEEP_ENABLE_BIT,
    input  wire logic           SLEEP_INSTR,
    input  wire logic           DEBUG_BREAK,
    // protected register access
    input  wire logic           KEY_WR,
    input  wire logic [7:0]     KEY_DATA,
    input  wire logic           INSTR_RETIRED,
    input  wire logic           REG_WR,
    input  wire logic [7:0]     REG_WDATA,
    // run-in-standby bits
    input  wire logic           RSB_MAIN,
    input  wire logic           RSB_CCL,
    input  wire logic           RSB_DAC,
    input  wire logic           RSB_RTC,
    input  wire logic           RSB_ADC,
    input  wire logic           RSB_AC,
    // wake sources
    input  wire logic           IRQ_PIN,
    input  wire logic           PIN_ASYNC,
    input  wire logic           IRQ_VLM,
    input  wire logic           IRQ_MULTI_VOLTAGE_IO,
    input  wire logic           IRQ_RTC,
    input  wire logic           IRQ_PIT,
    input  wire logic           IRQ_TWI_MATCH,
    input  wire logic           IRQ_CCL,
    input  wire logic [2:0]     CCL_FILTER_SELECT,
    input  wire logic [1:0]     CCL_EDGE_DETECT,
    input  wire logic           IRQ_USART_SOF,
    input  wire logic           IRQ_ADC,
    input  wire logic           IRQ_AC,
    input  wire logic           IRQ_OTHER,
    // start-up status
    input  wire logic           OSC_READY,
    input  wire logic           REG_READY,
    input  wire logic           BOD_READY,
    input  wire logic [1:0]     BOD_ACTIVE_FUSE,
    input  wire logic           INTERNAL_32K_OSCILLATOR_REQ,
    // cpu and gating outputs
    output smc_pkg::smc_mode_type SLEEP_MODE,
    output logic                CPU_HALT,
    output logic                RESUME,
    output logic                CLK_EN_MAIN,
    output logic                CLK_EN_CCL,
    output logic                CLK_EN_TCD,
    output logic                PER_EN_DAC,
    output logic                PER_EN_OTHER,
    output logic                RTC_COUNTER_EN,
    output logic                ALWAYS_ON_EN,
    output logic                INTERNAL_32K_OSCILLATOR_EN,
    output logic                REG_LOW_POWER,
    output logic                LOW_LEAKAGE,
    // protected register view
    output logic [7:0]          REGULATOR_CONTROL,
    output logic                WINDOW_OPEN
);
    import smc_pkg::*;

    smc_state_type state;       // controller state
    smc_state_type next_state;  // next controller state
    smc_mode_type  next_mode;   // next stored mode
    logic [2:0]    cnt;         // wake cycle counter
    logic          main_off;    // main clock stopped in this sleep
    logic          reg_off;     // regulator in low power this sleep
    logic          bod_meta;    // first synchroniser stage
    logic          bod_ready;   // synchronised brown-out ready

    smc_reg_if     regs();      // link to the protected register

    // register traffic travels to the protect block unchanged
    assign regs.key_wr        = KEY_WR;
    assign regs.key_data      = KEY_DATA;
    assign regs.instr_retired = INSTR_RETIRED;
    assign regs.reg_wr        = REG_WR;
    assign regs.reg_wdata     = REG_WDATA;

    smc_protect u_protect
    (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .bus (regs)
    );

    // register fields
    wire       htll   = regs.reg_value[`SMC_HTLL_BIT];
    wire [2:0] regulator_power_mode  = regs.reg_value[`SMC_REGULATOR_POWER_MODE_MSB:0];
    wire       p_auto = (regulator_power_mode == `SMC_REGULATOR_POWER_MODE_AUTO);

    // mode of the current sleep
    wire m_idle = (SLEEP_MODE == SMC_IDLE);
    wire m_stby = (SLEEP_MODE == SMC_STANDBY);
    wire m_pd   = (SLEEP_MODE == SMC_PDOWN);
    wire asleep = (state == SMC_SLEEP);
    // low leakage only bites in power-down with automatic regulator
    wire leak   = m_pd && htll && p_auto;

    // requested mode must be one of the three codes
    wire sel_ok = (SLEEP_MODE_SELECT == `SMC_MODE_IDLE) ||
                  (SLEEP_MODE_SELECT == `SMC_MODE_STANDBY) ||
                  (SLEEP_MODE_SELECT == `SMC_MODE_PDOWN);
    wire go     = SLEEP_INSTR && SLEEP_ENABLE_BIT && sel_ok;
    wire new_idle = (SLEEP_MODE_SELECT == `SMC_MODE_IDLE);
    wire new_stby = (SLEEP_MODE_SELECT == `SMC_MODE_STANDBY);

    // wake source selection per mode
    wire ccl_async = (CCL_FILTER_SELECT == 3'h0) &&
                     (CCL_EDGE_DETECT == 2'h0);
    wire wake_all  = IRQ_VLM || IRQ_MULTI_VOLTAGE_IO;
    wire wake_idle = IRQ_PIN || IRQ_CCL || IRQ_OTHER;
    wire wake_stby = IRQ_PIN || IRQ_PIT || (IRQ_RTC && RSB_RTC) ||
                     IRQ_TWI_MATCH || IRQ_USART_SOF ||
                     (IRQ_ADC && RSB_ADC) || (IRQ_AC && RSB_AC) ||
                     IRQ_CCL;
    // power-down: pin must sense asynchronously
    wire wake_pd   = (IRQ_PIN && PIN_ASYNC) || IRQ_PIT ||
                     (IRQ_TWI_MATCH && !leak) ||
                     (IRQ_CCL && !leak && ccl_async);
    wire wake = wake_all || (m_idle && wake_idle) ||
                (m_stby && wake_stby) || (m_pd && wake_pd);

    // start-up waits only for what this sleep switched off
    wire up_ok   = (!main_off || OSC_READY) && (!reg_off || REG_READY);
    wire bod_ok  = (BOD_ACTIVE_FUSE != `SMC_BOD_WAIT_CODE) || bod_ready;
    wire cnt_end = (cnt == `SMC_WAKE_CYCLES - 3'h1);

    // state sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            SMC_ACTIVE:
                if (go)
                    next_state = SMC_SLEEP;
            SMC_SLEEP:   // debug break wakes even with no irq
                if (wake || DEBUG_BREAK)
                    next_state = SMC_START;
            SMC_START:   // oscillator and regulator start-up
                if (up_ok)
                    next_state = SMC_COUNT;
            SMC_COUNT:   // six cycles, then brown-out gate
                if (cnt_end && bod_ok)
                    next_state = SMC_ACTIVE;
            default:
                next_state = SMC_ACTIVE;
        endcase
    end

    assign next_mode = (state == SMC_ACTIVE && go) ?
                       smc_mode_type'(SLEEP_MODE_SELECT) : SLEEP_MODE;

    // brown-out ready comes from an analog clock domain
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            bod_meta  <= 1'b0;
            bod_ready <= 1'b0;
        end
        else
        begin
            bod_meta  <= BOD_READY;
            bod_ready <= bod_meta;
        end
    end

    // state, mode, wake counter; reset always lands in active
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            state      <= SMC_ACTIVE;
            SLEEP_MODE <= SMC_IDLE;
            cnt        <= 3'h0;
        end
        else
        begin
            state      <= next_state;
            SLEEP_MODE <= next_mode;
            // counter saturates at the end value while bod lags
            cnt        <= (state != SMC_COUNT) ? 3'h0 :
                          cnt_end ? cnt : cnt + 3'h1;
        end
    end

    // what was switched off, caught on entry
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            main_off <= 1'b0;
            reg_off  <= 1'b0;
        end
        else if (state == SMC_ACTIVE && go)
        begin
            // idle keeps the main clock so its wake is one start cycle plus six counted cycles
            main_off <= !(new_idle || (new_stby && RSB_MAIN));
            reg_off  <= !new_idle && p_auto;
        end
    end

    // gating outputs; fast clocks off in power-down by construction
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            CPU_HALT       <= 1'b0;
            RESUME         <= 1'b0;
            CLK_EN_MAIN    <= 1'b1;
            CLK_EN_CCL     <= 1'b1;
            CLK_EN_TCD     <= 1'b1;
            PER_EN_DAC     <= 1'b1;
            PER_EN_OTHER   <= 1'b1;
            RTC_COUNTER_EN <= 1'b1;
            ALWAYS_ON_EN   <= 1'b1;
            INTERNAL_32K_OSCILLATOR_EN      <= 1'b0;
            REG_LOW_POWER  <= 1'b0;
            LOW_LEAKAGE    <= 1'b0;
        end
        else
        begin
            CPU_HALT       <= (next_state != SMC_ACTIVE);
            RESUME         <= (state == SMC_COUNT) &&
                              (next_state == SMC_ACTIVE);
            CLK_EN_MAIN    <= !asleep || m_idle ||
                              (m_stby && RSB_MAIN);
            CLK_EN_CCL     <= !asleep || m_idle ||
                              (m_stby && RSB_CCL);
            CLK_EN_TCD     <= !asleep || m_idle;
            PER_EN_DAC     <= !asleep || m_idle ||
                              (m_stby && RSB_DAC);
            PER_EN_OTHER   <= !asleep || m_idle;
            RTC_COUNTER_EN <= !asleep || m_idle ||
                              (m_stby && RSB_RTC);
            ALWAYS_ON_EN   <= 1'b1;
            INTERNAL_32K_OSCILLATOR_EN      <= INTERNAL_32K_OSCILLATOR_REQ;
            REG_LOW_POWER  <= asleep && !m_idle && p_auto;
            LOW_LEAKAGE    <= asleep && leak;
        end
    end

    // protected register view straight from its flops
    assign REGULATOR_CONTROL = regs.reg_value;
    assign WINDOW_OPEN       = regs.window_open;
endmodule

// [smc_checker.sv]
// port assertions for the sleep mode controller
`timescale 1ns/1ps
module smc_checker
import smc_pkg::*;
(
    // clock, reset and cpu requests
    input wire logic         SYS_CLK, SYS_RST, SLEEP_ENABLE_BIT,
    input wire logic         SLEEP_INSTR, DEBUG_BREAK, IRQ_OTHER,
    input wire logic [2:0]   SLEEP_MODE_SELECT,
    input wire logic [1:0]   BOD_ACTIVE_FUSE,
    input wire logic         INTERNAL_32K_OSCILLATOR_REQ,
    // protected register traffic
    input wire logic         KEY_WR, REG_WR, INSTR_RETIRED,
    input wire logic [7:0]   KEY_DATA, REG_WDATA, REGULATOR_CONTROL,
    input wire logic         WINDOW_OPEN,
    // outputs under watch
    input wire smc_mode_type SLEEP_MODE,
    input wire logic         CPU_HALT, RESUME, CLK_EN_MAIN, CLK_EN_TCD,
    input wire logic         PER_EN_OTHER, INTERNAL_32K_OSCILLATOR_EN, LOW_LEAKAGE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic take; // sleep request the controller must accept
    assign take = SLEEP_INSTR && SLEEP_ENABLE_BIT && !CPU_HALT
                  && SLEEP_MODE_SELECT <= 3'h2;
    AST_SLEEP_ENTRY: assert property (
        take |=> CPU_HALT && SLEEP_MODE == $past(SLEEP_MODE_SELECT))
        else $error("sleep request not taken");
    AST_SLEEP_REFUSED: assert property (
        SLEEP_INSTR && !CPU_HALT && !take |=> !CPU_HALT)
        else $error("refused sleep request taken");
    AST_IDLE_RUN: assert property (
        CPU_HALT && SLEEP_MODE == SMC_IDLE
        |-> CLK_EN_MAIN && CLK_EN_TCD && PER_EN_OTHER)
        else $error("clock stopped in idle");
    AST_GATE_ASLEEP: assert property (
        !(CLK_EN_TCD && PER_EN_OTHER) |-> CPU_HALT && SLEEP_MODE != SMC_IDLE)
        else $error("gating outside deep sleep");
    AST_IDLE_WAKE: assert property (
        CPU_HALT && $past(CPU_HALT) && SLEEP_MODE == SMC_IDLE
        && BOD_ACTIVE_FUSE != 2'h3 && $rose(IRQ_OTHER) && !DEBUG_BREAK
        |=> !RESUME [*7] ##1 RESUME) else $error("idle wake time wrong");
    AST_RESUME: assert property (
        RESUME |-> !CPU_HALT && $past(CPU_HALT) ##1 !RESUME)
        else $error("resume pulse wrong");
    AST_DEBUG_WAKE: assert property (
        CPU_HALT && DEBUG_BREAK |-> ##[1:40] RESUME)
        else $error("debug break did not wake");
    AST_REG_LOCKED: assert property (
        REG_WR && !WINDOW_OPEN |=> $stable(REGULATOR_CONTROL))
        else $error("unlocked write changed register");
    AST_REG_WRITE: assert property (
        REG_WR && WINDOW_OPEN && !KEY_WR
        |=> REGULATOR_CONTROL == ($past(REG_WDATA) & 8'h17) && !WINDOW_OPEN)
        else $error("keyed write not stored");
    AST_KEY_WINDOW: assert property (
        KEY_WR && KEY_DATA == 8'h5a ##1
        (INSTR_RETIRED && !REG_WR && !KEY_WR) [*4] |=> !WINDOW_OPEN)
        else $error("window open too long");
    AST_LEAK: assert property (
        LOW_LEAKAGE |-> CPU_HALT && SLEEP_MODE == SMC_PDOWN
        && REGULATOR_CONTROL[4] && REGULATOR_CONTROL[2:0] == 3'h0)
        else $error("low leakage out of place");
    AST_INTERNAL_32K_OSCILLATOR: assert property (
        !$past(SYS_RST) |-> INTERNAL_32K_OSCILLATOR_EN == $past(INTERNAL_32K_OSCILLATOR_REQ))
        else $error("32k enable not following request");
    // main scenarios reached
    cover property (take && SLEEP_MODE_SELECT == 3'h2);
    cover property (RESUME);
    cover property (LOW_LEAKAGE);
endmodule
bind smc_top smc_checker i_smc_checker (.*);

// [smc_partner.sv]
// start-up side: main oscillator, regulator, brown-out ready
`timescale 1ns/1ps
module smc_partner
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // controller side
    input  wire logic clk_en_main,
    input  wire logic reg_low_power,
    input  wire logic bod_hold,
    // ready levels
    output logic      osc_ready,
    output logic      reg_ready,
    output logic      bod_ready
);
    logic [3:0] osc_cnt; // cycles since main clock enabled
    logic [3:0] reg_cnt; // cycles since full drive returned
    // count start-up, saturating so ready stays up
    always_ff @(posedge clk)
    begin
        osc_cnt <= (rst || !clk_en_main) ? 4'h0 : osc_cnt + 4'h1;
        reg_cnt <= (rst || reg_low_power) ? 4'h0 : reg_cnt + 4'h1;
        if (osc_cnt == 4'hf)
            osc_cnt <= 4'hf;
        if (reg_cnt == 4'hf)
            reg_cnt <= 4'hf;
    end
    // a stopped source is never ready, so wake must wait
    assign osc_ready = clk_en_main && osc_cnt >= 4'h3;
    assign reg_ready = !reg_low_power && reg_cnt >= 4'h2;
    assign bod_ready = !bod_hold;
endmodule

// [testbench.sv]
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
module testbench;
    import smc_pkg::*;
    logic SYS_CLK = 0, SYS_RST = 1, SLEEP_ENABLE_BIT = 0, SLEEP_INSTR = 0;
    logic KEY_WR = 0, INSTR_RETIRED = 0, REG_WR = 0, bod_hold = 0;
    logic [2:0] SLEEP_MODE_SELECT = 0, CCL_FILTER_SELECT = 0;
    logic [7:0] KEY_DATA = 0, REG_WDATA = 0;
    logic [1:0] BOD_ACTIVE_FUSE = 0, CCL_EDGE_DETECT = 0;
    logic PIN_ASYNC = 0, INTERNAL_32K_OSCILLATOR_REQ = 0;
    logic [11:0] irq = 0; // wake sources, top bit is debug break
    logic [5:0] rsb = 0;  // run-in-standby bits
    wire logic DEBUG_BREAK, IRQ_PIN, IRQ_VLM, IRQ_MULTI_VOLTAGE_IO, IRQ_RTC, IRQ_PIT;
    wire logic IRQ_TWI_MATCH, IRQ_CCL, IRQ_USART_SOF, IRQ_ADC, IRQ_AC;
    wire logic IRQ_OTHER, RSB_MAIN, RSB_CCL, RSB_DAC, RSB_RTC, RSB_ADC;
    wire logic RSB_AC, OSC_READY, REG_READY, BOD_READY;
    smc_mode_type SLEEP_MODE;
    logic CPU_HALT, RESUME, CLK_EN_MAIN, CLK_EN_CCL, CLK_EN_TCD, PER_EN_DAC;
    logic PER_EN_OTHER, RTC_COUNTER_EN, ALWAYS_ON_EN, INTERNAL_32K_OSCILLATOR_EN;
    logic REG_LOW_POWER, LOW_LEAKAGE, WINDOW_OPEN;
    logic [7:0] REGULATOR_CONTROL;
    int failures = 0, n_tests = 0, cycles = 0;
    assign {DEBUG_BREAK, IRQ_OTHER, IRQ_AC, IRQ_ADC, IRQ_USART_SOF, IRQ_CCL,
            IRQ_TWI_MATCH, IRQ_PIT, IRQ_RTC, IRQ_MULTI_VOLTAGE_IO, IRQ_VLM, IRQ_PIN} = irq;
    assign {RSB_AC, RSB_ADC, RSB_RTC, RSB_DAC, RSB_CCL, RSB_MAIN} = rsb;
    smc_top i_smc_top (.*);
    smc_partner i_smc_partner (.clk(SYS_CLK), .rst(SYS_RST),
        .clk_en_main(CLK_EN_MAIN), .reg_low_power(REG_LOW_POWER),
        .bod_hold(bod_hold), .osc_ready(OSC_READY), .reg_ready(REG_READY),
        .bod_ready(BOD_READY));
    always #2.5 SYS_CLK = ~SYS_CLK;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            end_of_test;
        end
    end
    task nclk(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask
    // one sleep instruction, then let gating settle
    task sleep(input logic [2:0] m, input logic sleep_enable_bit);
        SLEEP_MODE_SELECT = m;
        SLEEP_ENABLE_BIT = sleep_enable_bit;
        SLEEP_INSTR = 1;
        nclk(1);
        SLEEP_INSTR = 0;
        nclk(2);
    endtask
    // raise a source and count cycles up to the resume pulse
    task wake(input int b, output int n);
        irq[b] = 1;
        n = 0;
        while (RESUME !== 1'b1 && n < 60)
        begin
            nclk(1);
            n++;
        end
        irq[b] = 0;
    endtask
    // a source that must not wake this mode
    task stay(input int b);
        irq[b] = 1;
        nclk(12);
        chk(CPU_HALT, 8'h01);
        irq[b] = 0;
        nclk(1);
    endtask
    // key, some instructions, then the protected write
    task prot(input logic [7:0] k, input logic [7:0] d, input int gap);
        KEY_WR = 1;
        KEY_DATA = k;
        nclk(1);
        KEY_WR = 0;
        INSTR_RETIRED = (gap > 0);
        nclk(gap);
        INSTR_RETIRED = 0;
        REG_WR = 1;
        REG_WDATA = d;
        nclk(1);
        REG_WR = 0;
    endtask
    task t_basic;
        chk({CLK_EN_MAIN, CLK_EN_CCL, CLK_EN_TCD, PER_EN_DAC, PER_EN_OTHER,
             RTC_COUNTER_EN, ALWAYS_ON_EN, CPU_HALT}, 8'hfe);
        chk(REGULATOR_CONTROL, 8'h00);
        sleep(3'h0, 1'b0);
        chk(CPU_HALT, 8'h00);
        sleep(3'h5, 1'b1);
        chk(CPU_HALT, 8'h00);
        prot(8'ha5, 8'h01, 0);
        chk(REGULATOR_CONTROL, 8'h00);
        prot(8'h5a, 8'hff, 0);
        chk(REGULATOR_CONTROL, 8'h17);
        prot(8'h5a, 8'h01, 4);
        chk(REGULATOR_CONTROL, 8'h17);
        prot(8'h5a, 8'h01, 3);
        chk(REGULATOR_CONTROL, 8'h01);
        $display("basic done");
    endtask
    task t_idle;
        int n;
        sleep(3'h0, 1'b1);
        chk(SLEEP_MODE, 8'h00);
        chk({CLK_EN_MAIN, CLK_EN_TCD, PER_EN_DAC, PER_EN_OTHER}, 8'h0f);
        stay(3);
        stay(5);
        wake(10, n);
        chk(n, 8'h08);
        $display("idle done");
    endtask
    task t_standby;
        int n;
        rsb = 6'b000100;
        sleep(3'h1, 1'b1);
        chk({CLK_EN_MAIN, CLK_EN_CCL, CLK_EN_TCD, PER_EN_DAC, PER_EN_OTHER,
             RTC_COUNTER_EN}, 8'h04);
        stay(3);
        stay(8);
        wake(7, n);
        chk(n > 8, 8'h01);
        rsb = 6'b111111;
        sleep(3'h1, 1'b1);
        chk({CLK_EN_MAIN, CLK_EN_CCL, CLK_EN_TCD, PER_EN_DAC, PER_EN_OTHER,
             RTC_COUNTER_EN}, 8'h35);
        wake(3, n);
        chk(n, 8'h08);
        sleep(3'h1, 1'b1);
        wake(11, n);
        chk(CPU_HALT, 8'h00);
        $display("standby done");
    endtask
    task t_pdown;
        int n;
        prot(8'h5a, 8'h10, 0);
        INTERNAL_32K_OSCILLATOR_REQ = 1;
        sleep(3'h2, 1'b1);
        chk({CLK_EN_MAIN, CLK_EN_CCL, CLK_EN_TCD, PER_EN_DAC, PER_EN_OTHER,
             RTC_COUNTER_EN}, 8'h00);
        chk({LOW_LEAKAGE, REG_LOW_POWER, ALWAYS_ON_EN, INTERNAL_32K_OSCILLATOR_EN},
            8'h0f);
        stay(0);
        stay(5);
        stay(6);
        wake(4, n);
        chk(n > 8, 8'h01);
        prot(8'h5a, 8'h00, 0);
        sleep(3'h2, 1'b1);
        CCL_EDGE_DETECT = 2'h1;
        stay(6);
        CCL_EDGE_DETECT = 2'h0;
        wake(6, n);
        chk(CPU_HALT, 8'h00);
        PIN_ASYNC = 1;
        sleep(3'h2, 1'b1);
        wake(0, n);
        chk(CPU_HALT, 8'h00);
        $display("power-down done");
    endtask
    task t_bod_rst;
        int n;
        BOD_ACTIVE_FUSE = 2'h3;
        bod_hold = 1;
        sleep(3'h0, 1'b1);
        irq[10] = 1;
        nclk(20);
        chk(CPU_HALT, 8'h01);
        bod_hold = 0;
        wake(10, n);
        chk(CPU_HALT, 8'h00);
        sleep(3'h2, 1'b1);
        SYS_RST = 1;
        nclk(20);
        SYS_RST = 0;
        chk(CPU_HALT, 8'h00);
        $display("brown-out and reset done");
    endtask
    initial
    begin
        nclk(20);
        SYS_RST = 0;
        t_basic;
        t_idle;
        t_standby;
        t_pdown;
        t_bod_rst;
        end_of_test;
    end
endmodule
